// file: hdl/vrc_bias_demand.sv
`timescale 1ns/1ps
// ==========================================================
// bias request combiner
module vrc_bias_demand
(
	input wire logic stored,
	input wire logic converterOn,
	input wire logic tempOn,
	input wire logic oscOn,
	output logic biasOn
);
	import vrc_pkg::*;
	// users force the bias generator on
	always_comb
	begin
		biasOn = stored | converterOn | tempOn | oscOn;
	end
endmodule

// file: hdl/vrc_pkg.sv
package vrc_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] REF_CTRL_ADDR = 8'hD1;
	localparam logic [7:0] REF_CTRL_RESET = 8'h00;
	localparam logic [7:0] REF_CTRL_WMASK = 8'h3F;
	// ==========================================================
	// field positions
	localparam int BUF_EN_BIT = 0;
	localparam int BIAS_EN_BIT = 1;
	localparam int TEMP_EN_BIT = 2;
	localparam int SRC_SEL_BIT = 3;
	localparam int LVL_SEL_BIT = 4;
	localparam int ZTC_BIT = 5;
	// ==========================================================
	// field encodings
	localparam logic SRC_PIN = 1'b0;
	localparam logic SRC_SUPPLY = 1'b1;
	localparam logic LVL_1V5 = 1'b0;
	localparam logic LVL_2V2 = 1'b1;
	typedef enum logic [0:0] {ACC_IDLE = 1'b0, ACC_WRITE = 1'b1} vrc_acc_type;
endpackage

// file: hdl/vrc_reference_control.sv
`timescale 1ns/1ps
// Function
// - source select 0 routes reference pin, 1 routes supply to mux
// - bias generator on whenever converter, sensor or oscillator enabled
// - bias field 1 keeps generator on; 0 means on demand only
// - level select 0 gives 1.5 V, 1 gives 2.2 V
// - buffer field 1 enables buffer driving pin; 0 disables it
// - sensor on when 1; off means output held high impedance
// - zero-tc force 1 holds that generator on; 0 automatic
module vrc_reference_control
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic converterOn,
	input wire logic oscOn,
	input wire logic ztcNeeded,
	output logic srcSelSupply,
	output logic lvlSel2v2,
	output logic bufEnable,
	output logic tempSensorOn,
	output logic tempSensorHiZ,
	output logic biasGenOn,
	output logic ztcBiasOn
);
	import vrc_pkg::*;
	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic srcSel;
		logic lvl;
		logic buf_;
		logic temp;
		logic hiz;
		logic bias;
		logic ztc;
		vrc_acc_type acc;
		logic [1:0] convSync;
		logic [1:0] oscSync;
		logic [1:0] ztcSync;
	} vrc_state_type;
	// reset image: register cleared, sensor output parked high impedance
	localparam vrc_state_type ST_RESET = '{
		ctrl: REF_CTRL_RESET,
		hiz: 1'b1,
		acc: ACC_IDLE,
		default: '0
	};
	vrc_state_type st;
	vrc_state_type next_st;
	logic writeHit;
	logic [7:0] nextCtrl;
	logic biasDemand;
	logic ztcCtl;
	// ==========================================================
	// register decode
	// one select term shared by write, read and the checks
	function automatic logic ctrlSelected(input logic [7:0] addr);
		return addr == REF_CTRL_ADDR;
	endfunction
	// write lands at the next edge; reserved bits dropped on the way in
	assign writeHit = regWrite && ctrlSelected(regAddr);
	assign nextCtrl = writeHit ? (regWdata & REF_CTRL_WMASK) : st.ctrl;
	// ==========================================================
	// bias demand
	// fed from the value the edge will store, so a write and its
	// bias effect show together one cycle after the strobe
	vrc_bias_demand uDemand
	(
		.stored(nextCtrl[BIAS_EN_BIT]),
		.converterOn(st.convSync[1]),
		.tempOn(nextCtrl[TEMP_EN_BIT]),
		.oscOn(st.oscSync[1]),
		.biasOn(biasDemand)
	);
	// ==========================================================
	// next-state logic
	always_comb
	begin
		next_st = st;
		// demand pins come from the analog domain: two flops before use
		next_st.convSync = {st.convSync[0], converterOn};
		next_st.oscSync = {st.oscSync[0], oscOn};
		next_st.ztcSync = {st.ztcSync[0], ztcNeeded};
		// write marker lasts one cycle
		next_st.acc = ACC_IDLE;
		if (writeHit)
		begin
			next_st.acc = ACC_WRITE;
		end
		next_st.ctrl = nextCtrl;
		// registered read data; other addresses read as zero
		next_st.rdata = ctrlSelected(regAddr) ? nextCtrl : 8'h00;
		// field decode; all outputs move together
		next_st.srcSel = nextCtrl[SRC_SEL_BIT];
		next_st.lvl = nextCtrl[LVL_SEL_BIT];
		next_st.buf_ = nextCtrl[BUF_EN_BIT];
		next_st.temp = nextCtrl[TEMP_EN_BIT];
		next_st.hiz = ~nextCtrl[TEMP_EN_BIT];
		next_st.bias = biasDemand;
		// forced by the field or on demand from its users
		ztcCtl = nextCtrl[ZTC_BIT] | st.ztcSync[1];
		next_st.ztc = ztcCtl;
	end
	// ==========================================================
	// state register
	// reset branch loads a constant image only
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= ST_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end
	// ==========================================================
	// outputs straight from flops
	assign regRdata = st.rdata;
	assign srcSelSupply = st.srcSel;
	assign lvlSel2v2 = st.lvl;
	assign bufEnable = st.buf_;
	assign tempSensorOn = st.temp;
	assign tempSensorHiZ = st.hiz;
	assign biasGenOn = st.bias;
	assign ztcBiasOn = st.ztc;
	// ==========================================================
	// checks
	// ==========================================================
	// write path: field outputs follow the written byte
	a_src_follow: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit |=> srcSelSupply == $past(regWdata[SRC_SEL_BIT]))
		else $error("source select mismatch");
	a_src_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!writeHit |=> $stable(srcSelSupply))
		else $error("source select moved without write");
	a_lvl_follow: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit |=> lvlSel2v2 == $past(regWdata[LVL_SEL_BIT]))
		else $error("level select mismatch");
	a_buf_follow: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit |=> bufEnable == $past(regWdata[BUF_EN_BIT]))
		else $error("buffer enable mismatch");
	a_temp_follow: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit |=> tempSensorOn == $past(regWdata[TEMP_EN_BIT]))
		else $error("sensor enable mismatch");
	a_sensor_off: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit && !regWdata[TEMP_EN_BIT] |=> tempSensorHiZ)
		else $error("sensor output not parked");
	a_temp_hiz: assert property (@(posedge clk) disable iff (!reset_n)
		tempSensorHiZ == !tempSensorOn)
		else $error("sensor hiz wrong");
	// ==========================================================
	// bias generator: forced by its users, held by the field
	// demand arrives two flops late; checks key on the synchronised copy
	a_bias_forced: assert property (@(posedge clk) disable iff (!reset_n)
		st.convSync[1] |=> biasGenOn)
		else $error("bias not forced by converter");
	a_bias_osc: assert property (@(posedge clk) disable iff (!reset_n)
		st.oscSync[1] |=> biasGenOn)
		else $error("bias not forced by oscillator");
	a_bias_sensor: assert property (@(posedge clk) disable iff (!reset_n)
		nextCtrl[TEMP_EN_BIT] |=> biasGenOn)
		else $error("bias not forced by sensor");
	a_bias_stored: assert property (@(posedge clk) disable iff (!reset_n)
		st.ctrl[BIAS_EN_BIT] && !regWrite |=> biasGenOn)
		else $error("bias field not honoured");
	a_bias_written: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit && regWdata[BIAS_EN_BIT] |=> biasGenOn)
		else $error("bias write not honoured");
	a_bias_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!nextCtrl[BIAS_EN_BIT] && !nextCtrl[TEMP_EN_BIT] && !st.convSync[1] && !st.oscSync[1] |=> !biasGenOn)
		else $error("bias on without demand");
	// ==========================================================
	// zero-tc bias: forced by the field or on demand
	a_ztc_force: assert property (@(posedge clk) disable iff (!reset_n)
		st.ctrl[ZTC_BIT] && !regWrite |=> ztcBiasOn)
		else $error("zero-tc force ignored");
	a_ztc_demand: assert property (@(posedge clk) disable iff (!reset_n)
		st.ztcSync[1] |=> ztcBiasOn)
		else $error("zero-tc demand ignored");
	a_ztc_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!nextCtrl[ZTC_BIT] && !st.ztcSync[1] |=> !ztcBiasOn)
		else $error("zero-tc on without demand");
	// ==========================================================
	// register: reserved bits never reach the stored value
	a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
		regRdata[7:6] == 2'b00)
		else $error("reserved bits not zero");
	a_read_back: assert property (@(posedge clk) disable iff (!reset_n)
		writeHit |=> regRdata == ($past(regWdata) & REF_CTRL_WMASK))
		else $error("read-back after write wrong");
	a_read_held: assert property (@(posedge clk) disable iff (!reset_n)
		ctrlSelected(regAddr) && !regWrite |=> regRdata == $past(st.ctrl))
		else $error("read of stored value wrong");
	a_read_other: assert property (@(posedge clk) disable iff (!reset_n)
		!ctrlSelected(regAddr) |=> regRdata == 8'h00)
		else $error("unmapped address read not zero");
	a_other_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && !ctrlSelected(regAddr) |=> st.ctrl == $past(st.ctrl))
		else $error("write to other address landed");
	a_ctrl_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!writeHit |=> $stable(st.ctrl))
		else $error("control moved without write");
	// ==========================================================
	// main scenarios
	c_write_ctrl: cover property (@(posedge clk) regWrite && regAddr == REF_CTRL_ADDR);
	c_write_done: cover property (@(posedge clk) st.acc == ACC_WRITE);
	c_bias_demand: cover property (@(posedge clk) st.oscSync[1] && !st.ctrl[BIAS_EN_BIT] ##1 biasGenOn);
	c_ztc_demand: cover property (@(posedge clk) st.ztcSync[1] && !st.ctrl[ZTC_BIT] ##1 ztcBiasOn);
	c_temp_on: cover property (@(posedge clk) tempSensorOn);
endmodule

// file: tb/vrc_reference_control_bench.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the reference control register
module vrc_reference_control_bench;
	import vrc_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic regWrite = 1'b0;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic converterOn = 1'b0;
	logic oscOn = 1'b0;
	logic ztcNeeded = 1'b0;
	logic [6:0] outs;
	int mismatches = 0;
	int numChecks = 0;
	// 200 MHz clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// outputs packed in field order, high-impedance flag on top
	vrc_reference_control i_dut
	(
		.clk(clk),
		.reset_n(reset_n),
		.regAddr(regAddr),
		.regWrite(regWrite),
		.regWdata(regWdata),
		.regRdata(regRdata),
		.converterOn(converterOn),
		.oscOn(oscOn),
		.ztcNeeded(ztcNeeded),
		.srcSelSupply(outs[3]),
		.lvlSel2v2(outs[4]),
		.bufEnable(outs[0]),
		.tempSensorOn(outs[2]),
		.tempSensorHiZ(outs[6]),
		.biasGenOn(outs[1]),
		.ztcBiasOn(outs[5])
	);
	// compare one value
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one-cycle write strobe, then outputs are settled
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		regAddr = addr;
		regWdata = data;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
		@(negedge clk);
	endtask
	// registered read: address one edge ahead of the data
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		regAddr = addr;
		@(negedge clk);
		chk("regRdata", exp, regRdata);
	endtask
	// demand levels, then wait past the synchroniser
	task automatic dem(input logic [2:0] d);
		{converterOn, oscOn, ztcNeeded} = d;
		repeat (4) @(negedge clk);
	endtask
	// verdict and end of run
	task report_and_stop;
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		chk("outputs", 8'h40, {1'b0, outs});
		rd(REF_CTRL_ADDR, REF_CTRL_RESET);
		// reference pin taken as analog and crossbar-skipped by port setup outside
		wr(REF_CTRL_ADDR, 8'hFF);
		chk("outputs", 8'h3F, {1'b0, outs});
		rd(REF_CTRL_ADDR, 8'h3F);
		wr(8'hD0, 8'h00);
		rd(REF_CTRL_ADDR, 8'h3F);
		rd(8'hD2, 8'h00);
		// each field alone; sensor on also asks for bias
		for (int i = 0; i < 6; i++)
		begin
			wr(REF_CTRL_ADDR, 8'h01 << i);
			chk("field", (8'h01 << i) | ((i == 2) ? 8'h02 : 8'h40), {1'b0, outs});
		end
		// mid-run reset clears the register and parks the sensor output
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		chk("reset outputs", 8'h40, {1'b0, outs});
		rd(REF_CTRL_ADDR, REF_CTRL_RESET);
		// buffer left off while the internal reference is unused
		wr(REF_CTRL_ADDR, 8'h00);
		dem(3'b100);
		chk("converter demand", 8'h42, {1'b0, outs});
		dem(3'b010);
		chk("oscillator demand", 8'h42, {1'b0, outs});
		dem(3'b001);
		chk("zero-tc demand", 8'h60, {1'b0, outs});
		dem(3'b000);
		chk("no demand", 8'h40, {1'b0, outs});
		report_and_stop();
	end
	// watchdog well beyond the sequence length
	initial
	begin
		#20000;
		mismatches++;
		report_and_stop();
	end
endmodule
